//--- core/iod_pkg.sv
// Purpose: shared constants and types of the io space decoder
// Assumes: 8-bit registers, 6-bit io addresses, 8-bit data addresses
// Notes:   register masks give the implemented bits of each address

package iod_pkg;

  // ==========================================================
  // sizes and windows
  localparam int         DATA_W        = 8;
  localparam int         IO_AW         = 6;
  localparam int         STORE_DEPTH   = 32;
  localparam logic [7:0] IO_DATA_BASE  = 8'h20;
  localparam logic [7:0] EXT_DATA_BASE = 8'h60;
  localparam logic [5:0] BIT_OP_LAST   = 6'h1f;
  localparam logic [5:0] STORE_BASE    = 6'h20;
  localparam logic [7:0] RESET_VAL     = 8'h00;

  // ==========================================================
  // io offsets of the low registers
  localparam logic [5:0] OFS_PIN_B  = 6'h03;
  localparam logic [5:0] OFS_DDR_B  = 6'h04;
  localparam logic [5:0] OFS_OUT_B  = 6'h05;
  localparam logic [5:0] OFS_PIN_C  = 6'h06;
  localparam logic [5:0] OFS_DDR_C  = 6'h07;
  localparam logic [5:0] OFS_OUT_C  = 6'h08;
  localparam logic [5:0] OFS_PIN_D  = 6'h09;
  localparam logic [5:0] OFS_DDR_D  = 6'h0a;
  localparam logic [5:0] OFS_OUT_D  = 6'h0b;
  localparam logic [5:0] OFS_TF0    = 6'h15;
  localparam logic [5:0] OFS_TF1    = 6'h16;
  localparam logic [5:0] OFS_TF2    = 6'h17;
  localparam logic [5:0] OFS_PCF    = 6'h1b;
  localparam logic [5:0] OFS_IRQ_MK = 6'h1d;
  localparam logic [5:0] OFS_SCR0   = 6'h1e;
  localparam logic [5:0] OFS_EE_CTL = 6'h1f;

  // ==========================================================
  // region codes of a decoded address
  localparam logic [1:0] REGION_IO   = 2'h0;
  localparam logic [1:0] REGION_EXT  = 2'h1;
  localparam logic [1:0] REGION_CORE = 2'h2;

  typedef enum logic [3:0] {
    IO_READ_OP             = 4'h0,
    IO_WRITE_OP            = 4'h1,
    SET_IO_BIT_OP          = 4'h2,
    CLEAR_IO_BIT_OP        = 4'h3,
    SKIP_IF_IO_BIT_HIGH_OP = 4'h4,
    SKIP_IF_IO_BIT_LOW_OP  = 4'h5,
    DATA_LOAD_OP           = 4'h6,
    DATA_SAVE_OP           = 4'h7
  } iod_op_t;

  typedef struct packed {
    logic       valid;
    iod_op_t    op;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } iod_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
    logic       bit_val;
    logic       skip;
    logic       ignored;
  } iod_rsp_t;

  typedef struct packed {
    logic [7:0] pin_b;
    logic [7:0] pin_c;
    logic [7:0] pin_d;
  } iod_pins_t;

  typedef struct packed {
    logic [7:0] timer0;
    logic [7:0] timer1;
    logic [7:0] timer2;
    logic [7:0] pin_change;
  } iod_flags_t;

  typedef struct packed {
    logic [7:0] ddr_b;
    logic [7:0] out_b;
    logic [7:0] ddr_c;
    logic [7:0] out_c;
    logic [7:0] ddr_d;
    logic [7:0] out_d;
    logic [7:0] tf0;
    logic [7:0] tf1;
    logic [7:0] tf2;
    logic [7:0] pcf;
    logic [7:0] irq_mask;
    logic [7:0] scratch0;
    logic [7:0] ee_ctl;
  } iod_low_t;

  typedef struct packed {
    logic       req;
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iod_ext_t;

  // implemented bits per io address, zero for reserved ones
  function automatic logic [7:0] io_bits(input logic [5:0] a);
    case (a)
      6'h03, 6'h04, 6'h05, 6'h09, 6'h0a, 6'h0b: io_bits = 8'hff;
      6'h06, 6'h07, 6'h08:                      io_bits = 8'h7f;
      6'h15, 6'h17, 6'h1b:                      io_bits = 8'h07;
      6'h16:                                    io_bits = 8'h27;
      6'h1d:                                    io_bits = 8'h03;
      6'h1e:                                    io_bits = 8'hff;
      6'h1f:                                    io_bits = 8'h3f;
      6'h20, 6'h21, 6'h22, 6'h26, 6'h27, 6'h28: io_bits = 8'hff;
      6'h2a, 6'h2b, 6'h2c, 6'h2e, 6'h30:        io_bits = 8'hff;
      6'h23:                                    io_bits = 8'h83;
      6'h24:                                    io_bits = 8'hf3;
      6'h25:                                    io_bits = 8'hcf;
      6'h2d:                                    io_bits = 8'hc1;
      default:                                  io_bits = 8'h00;
    endcase
  endfunction

  // status flag registers cleared by writing one
  function automatic logic is_w1c(input logic [5:0] a);
    is_w1c = (a == OFS_TF0) || (a == OFS_TF1) || (a == OFS_TF2) || (a == OFS_PCF);
  endfunction

endpackage

//--- core/iod_store.sv
// Purpose: byte store for the upper io window
// Assumes: one write and one read per cycle
// Notes:   read data appear one cycle after the address

`timescale 1ns/100ps

module iod_store #(
  parameter int DEPTH = 32,
  parameter int W     = 8
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // write side
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [W-1:0]             wr_data,
  // read side
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [W-1:0]             rd_data
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0]            rdata;
  } iod_store_st_t;

  iod_store_st_t st_d;
  iod_store_st_t st_q;

  // read sees the old byte on a same-cycle write
  always_comb
  begin
    st_d = st_q;
    st_d.rdata = st_q.mem[rd_addr];
    if (wr_en)
    begin
      st_d.mem[wr_addr] = wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign rd_data = st_q.rdata;
endmodule

//--- core/iod_bitop.sv
// Purpose: value written back by a single-bit set or clear
// Assumes: caller applies the result through the normal write path
// Notes:   for one-to-clear registers only the chosen bit is touched

`timescale 1ns/100ps

module iod_bitop (
  // operands
  input  wire logic [7:0] old_val,
  input  wire logic [2:0] bit_sel,
  input  wire logic       set_bit,
  input  wire logic       w1c,
  // result
  output logic      [7:0] wr_val
);
  logic [7:0] one_hot;

  // a flag register must never see its other ones written back
  always_comb
  begin
    one_hot = 8'h01 << bit_sel;
    if (w1c)
      wr_val = set_bit ? one_hot : 8'h00; // [R06]
    else if (set_bit)
      wr_val = old_val | one_hot;
    else
      wr_val = old_val & ~one_hot;
  end
endmodule

//--- core/iod_decoder.sv
// Purpose: io space decoder and low register bank for the core
// Assumes: one request at a time, answer two cycles after taking
// Notes:   upper io window kept in a byte store, extended range
//          forwarded on the extended bus
//
// Functional notes
// [R01] software writes zero to reserved bits
// [R02] software never writes reserved io addresses
// [R03] bit set and clear only below 0x20
// [R04] skip tests report chosen bit, low range
// [R05] some flags clear on writing one
// [R06] bit operation touches only the chosen bit
// [R07] io read and write use 0x00 to 0x3f
// [R08] data address equals io address plus 0x20
// [R09] extended range reachable by load/store only
// [R10] reserved reads zero, reserved writes ignored

`timescale 1ns/100ps

module iod_decoder
  import iod_pkg::*;
(
  // clock and reset
  input  wire logic               REF_CLK,
  input  wire logic               RST,
  // core request and answer
  input  wire iod_pkg::iod_req_t  REQ,
  output logic                    REQ_READY,
  output iod_pkg::iod_rsp_t       RSP,
  // peripheral side
  input  wire iod_pkg::iod_pins_t  PINS,
  input  wire iod_pkg::iod_flags_t FLAG_SET,
  output iod_pkg::iod_low_t        LOW_REGS,
  // extended range bus
  output iod_pkg::iod_ext_t        EXT_BUS,
  input  wire logic [7:0]          EXT_RDATA
);
  import iod_pkg::*;

  // ==========================================================
  // state
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_BUSY = 2'h2
  } iod_fsm_t;

  typedef struct packed {
    logic [1:0] region;
    logic [5:0] io;
  } iod_dec_t;

  typedef struct packed {
    iod_fsm_t  fsm;
    logic      ready;
    iod_req_t  pend;
    iod_dec_t  dec;
    iod_low_t  low;
    iod_rsp_t  rsp;
    iod_ext_t  ext;
  } iod_top_st_t;

  iod_top_st_t st_d;
  iod_top_st_t st_q;

  iod_dec_t   dec_in;
  logic [7:0] low_old;
  logic [7:0] bit_val;
  logic [7:0] wval;
  logic [7:0] rval;
  logic [7:0] store_rd;
  logic       store_we;
  logic       is_wr;
  logic       is_bit;
  logic       is_skip;
  logic       bad;

  // ==========================================================
  // decoding helpers
  function automatic iod_dec_t decode(input iod_req_t r);
    iod_dec_t d;
    d.region = REGION_IO;
    d.io = r.addr[5:0];
    if (r.op == DATA_LOAD_OP || r.op == DATA_SAVE_OP)
    begin
      if (r.addr < IO_DATA_BASE)
        d.region = REGION_CORE;
      else if (r.addr >= EXT_DATA_BASE)
        d.region = REGION_EXT; // [R09]
      else
        d.io = 6'(r.addr - IO_DATA_BASE); // [R08]
    end
    return d;
  endfunction

  function automatic logic [7:0] low_read(input iod_low_t l, input iod_pins_t p,
                                          input logic [5:0] a);
    case (a)
      OFS_PIN_B:  low_read = p.pin_b;
      OFS_DDR_B:  low_read = l.ddr_b;
      OFS_OUT_B:  low_read = l.out_b;
      OFS_PIN_C:  low_read = p.pin_c;
      OFS_DDR_C:  low_read = l.ddr_c;
      OFS_OUT_C:  low_read = l.out_c;
      OFS_PIN_D:  low_read = p.pin_d;
      OFS_DDR_D:  low_read = l.ddr_d;
      OFS_OUT_D:  low_read = l.out_d;
      OFS_TF0:    low_read = l.tf0;
      OFS_TF1:    low_read = l.tf1;
      OFS_TF2:    low_read = l.tf2;
      OFS_PCF:    low_read = l.pcf;
      OFS_IRQ_MK: low_read = l.irq_mask;
      OFS_SCR0:   low_read = l.scratch0;
      OFS_EE_CTL: low_read = l.ee_ctl;
      default:    low_read = 8'h00;
    endcase
  endfunction

  // v is already masked to the implemented bits
  function automatic iod_low_t low_write(input iod_low_t l, input logic [5:0] a,
                                         input logic [7:0] v);
    iod_low_t n;
    n = l;
    case (a)
      OFS_DDR_B:  n.ddr_b = v;
      OFS_OUT_B:  n.out_b = v;
      OFS_DDR_C:  n.ddr_c = v;
      OFS_OUT_C:  n.out_c = v;
      OFS_DDR_D:  n.ddr_d = v;
      OFS_OUT_D:  n.out_d = v;
      OFS_TF0:    n.tf0 = l.tf0 & ~v; // [R05]
      OFS_TF1:    n.tf1 = l.tf1 & ~v; // [R05]
      OFS_TF2:    n.tf2 = l.tf2 & ~v; // [R05]
      OFS_PCF:    n.pcf = l.pcf & ~v; // [R05]
      OFS_IRQ_MK: n.irq_mask = v;
      OFS_SCR0:   n.scratch0 = v;
      OFS_EE_CTL: n.ee_ctl = v;
      default:    n = l; // pins and reserved stay as they are
    endcase
    return n;
  endfunction

  // ==========================================================
  // submodules
  assign dec_in  = decode(REQ);
  assign low_old = low_read(st_q.low, PINS, dec_in.io);

  iod_bitop u_bitop (
    .old_val (low_old),
    .bit_sel (REQ.bit_sel),
    .set_bit (REQ.op == SET_IO_BIT_OP),
    .w1c     (is_w1c(dec_in.io)),
    .wr_val  (bit_val)
  );

  iod_store #(
    .DEPTH (STORE_DEPTH),
    .W     (DATA_W)
  ) u_store (
    .clk     (REF_CLK),
    .rst     (RST),
    .wr_en   (store_we),
    .wr_addr (dec_in.io[4:0]),
    .wr_data (wval),
    .rd_addr (dec_in.io[4:0]),
    .rd_data (store_rd)
  );

  // ==========================================================
  // request classification in the taking cycle
  always_comb
  begin
    is_wr = (REQ.op == IO_WRITE_OP || REQ.op == DATA_SAVE_OP) &&
            dec_in.region == REGION_IO &&
            io_bits(dec_in.io) != 8'h00; // [R07] [R10]
    is_bit = (REQ.op == SET_IO_BIT_OP || REQ.op == CLEAR_IO_BIT_OP) &&
             dec_in.io <= BIT_OP_LAST &&
             io_bits(dec_in.io) != 8'h00; // [R03]
    wval = (is_bit ? bit_val : REQ.wdata) & io_bits(dec_in.io); // [R10]
    store_we = st_q.fsm == ST_IDLE && REQ.valid && is_wr &&
               dec_in.io >= STORE_BASE;
  end

  // ==========================================================
  // answer classification in the busy cycle
  always_comb
  begin
    is_skip = st_q.pend.op == SKIP_IF_IO_BIT_HIGH_OP ||
              st_q.pend.op == SKIP_IF_IO_BIT_LOW_OP;
    if (st_q.dec.region == REGION_EXT)
      rval = EXT_RDATA;
    else if (st_q.dec.region == REGION_CORE)
      rval = 8'h00;
    else if (st_q.dec.io >= STORE_BASE)
      rval = store_rd & io_bits(st_q.dec.io); // [R10]
    else
      rval = low_read(st_q.low, PINS, st_q.dec.io) & io_bits(st_q.dec.io);
    // bit tests and bit writes are dead above the low range
    bad = st_q.dec.region == REGION_CORE;
    if (is_skip || st_q.pend.op == SET_IO_BIT_OP ||
        st_q.pend.op == CLEAR_IO_BIT_OP)
      bad = bad || st_q.dec.io > BIT_OP_LAST; // [R03] [R04]
    if (st_q.dec.region == REGION_IO)
      bad = bad || io_bits(st_q.dec.io) == 8'h00;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    st_d = st_q;
    st_d.rsp = '0;
    st_d.ext = '0;
    case (st_q.fsm)
      ST_IDLE:
      begin
        if (REQ.valid)
        begin
          st_d.pend = REQ;
          st_d.dec = dec_in;
          st_d.fsm = ST_BUSY;
          st_d.ready = 1'b0;
          if ((is_wr || is_bit) && dec_in.io < STORE_BASE)
            st_d.low = low_write(st_q.low, dec_in.io, wval); // [R06]
          if (dec_in.region == REGION_EXT)
          begin
            st_d.ext.req = 1'b1; // [R09]
            st_d.ext.we = REQ.op == DATA_SAVE_OP;
            st_d.ext.addr = REQ.addr;
            st_d.ext.wdata = REQ.wdata;
          end
        end
      end
      ST_BUSY:
      begin
        st_d.fsm = ST_IDLE;
        st_d.ready = 1'b1;
        st_d.rsp.valid = 1'b1;
        st_d.rsp.ignored = bad;
        st_d.rsp.bit_val = bad ? 1'b0 : rval[st_q.pend.bit_sel];
        if (st_q.pend.op == IO_READ_OP || st_q.pend.op == DATA_LOAD_OP)
          st_d.rsp.rdata = rval;
        if (is_skip && !bad)
          st_d.rsp.skip = (st_q.pend.op == SKIP_IF_IO_BIT_HIGH_OP) ?
                          rval[st_q.pend.bit_sel] :
                          !rval[st_q.pend.bit_sel]; // [R04]
      end
      default:
      begin
        st_d.fsm = ST_IDLE;
        st_d.ready = 1'b1;
      end
    endcase
    // a flag raised in the clearing cycle survives the clear
    st_d.low.tf0 = st_d.low.tf0 | (FLAG_SET.timer0 & io_bits(OFS_TF0));
    st_d.low.tf1 = st_d.low.tf1 | (FLAG_SET.timer1 & io_bits(OFS_TF1));
    st_d.low.tf2 = st_d.low.tf2 | (FLAG_SET.timer2 & io_bits(OFS_TF2));
    st_d.low.pcf = st_d.low.pcf | (FLAG_SET.pin_change & io_bits(OFS_PCF));
  end

  // registers, ready raised straight out of reset
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      st_q <= '0;
      st_q.fsm <= ST_IDLE;
      st_q.ready <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  assign REQ_READY = st_q.ready;
  assign RSP       = st_q.rsp;
  assign LOW_REGS  = st_q.low;
  assign EXT_BUS   = st_q.ext;

  // ==========================================================
  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  logic take;
  assign take = REQ.valid && st_q.ready;

  a_answer_two_cycles: // [R07]
    assert property (take |-> ##1 !RSP.valid ##1 RSP.valid ##1 !RSP.valid)
    else $error("answer not two cycles after request");

  a_bit_op_high_range: // [R03]
    assert property (take && REQ.op == SET_IO_BIT_OP &&
                     REQ.addr[5] // io ops ignore addr[7:6]
                     |-> ##2 RSP.ignored)
    else $error("bit set above low range not ignored");

  a_skip_reports_bit: // [R04]
    assert property (take && REQ.op == SKIP_IF_IO_BIT_LOW_OP && !REQ.addr[5]
                     |-> ##2 (RSP.ignored || RSP.skip == !RSP.bit_val))
    else $error("skip low result wrong");

  a_flag_one_clears: // [R05]
    assert property (take && REQ.op == IO_WRITE_OP &&
                     REQ.addr[5:0] == OFS_TF0 && REQ.wdata[0] &&
                     !FLAG_SET.timer0[0]
                     |=> !LOW_REGS.tf0[0])
    else $error("flag not cleared by writing one");

  a_flag_zero_keeps: // [R05]
    assert property (take && REQ.op == IO_WRITE_OP &&
                     REQ.addr[5:0] == OFS_TF1 && REQ.wdata == 8'h00 &&
                     FLAG_SET.timer1 == 8'h00
                     |=> LOW_REGS.tf1 == $past(LOW_REGS.tf1))
    else $error("flag changed by writing zero");

  a_bit_set_single: // [R06]
    assert property (take && REQ.op == SET_IO_BIT_OP &&
                     REQ.addr[5:0] == OFS_OUT_B
                     |=> LOW_REGS.out_b == ($past(LOW_REGS.out_b) |
                                            (8'h01 << $past(REQ.bit_sel))))
    else $error("bit set touched other bits");

  a_bit_flag_others: // [R06]
    assert property (take && REQ.op == SET_IO_BIT_OP &&
                     REQ.addr[5:0] == OFS_PCF && FLAG_SET.pin_change == 8'h00
                     |=> LOW_REGS.pcf == ($past(LOW_REGS.pcf) &
                                          ~(8'h01 << $past(REQ.bit_sel))))
    else $error("bit set cleared other flags");

  a_data_offset_map: // [R08]
    assert property (take && REQ.op == DATA_SAVE_OP && REQ.addr == 8'h25
                     |=> LOW_REGS.out_b == $past(REQ.wdata))
    else $error("data address not offset by 0x20");

  a_ext_load_store: // [R09]
    assert property (EXT_BUS.req |-> $past(REQ.op == DATA_LOAD_OP ||
                                           REQ.op == DATA_SAVE_OP) &&
                     EXT_BUS.addr >= EXT_DATA_BASE)
    else $error("extended bus used by io operation");

  a_reserved_read_zero: // [R10]
    assert property (take && REQ.op == IO_READ_OP && REQ.addr[5:0] == 6'h0c
                     |-> ##2 RSP.rdata == 8'h00 && RSP.ignored)
    else $error("reserved address read not zero");

  a_reserved_write_none: // [R10]
    assert property (take && REQ.op == IO_WRITE_OP && REQ.addr[5:0] == 6'h02 &&
                     FLAG_SET == '0
                     |=> LOW_REGS == $past(LOW_REGS))
    else $error("reserved address write changed a register");

  c_skip_taken:
    cover property (RSP.valid && RSP.skip);
  c_ext_load:
    cover property (EXT_BUS.req && !EXT_BUS.we ##1 RSP.valid);
  c_flag_set_clear:
    cover property (take && REQ.op == IO_WRITE_OP && FLAG_SET.timer0 != 8'h00);
endmodule

//--- bench/iod_core_model.sv
// Purpose: core side model issuing one io request at a time
// Assumes: answer one edge after the take edge
// Notes:   request held until the take edge, then dropped

`timescale 1ns/100ps

module iod_core_model
  import iod_pkg::*;
(
  // clock
  input  wire logic              clk,
  // request and answer
  output iod_pkg::iod_req_t      req,
  input  wire logic              ready,
  input  wire iod_pkg::iod_rsp_t rsp
);
  initial req = '0;

  // ==========================================================
  // one transfer; reserved bits or addresses only when the bench asks
  task automatic xfer(input iod_req_t r, output iod_rsp_t got);
    int n;
    @(posedge clk);
    req <= r;
    @(negedge clk);
    // bounded wait of 50 cycles, a stuck ready never reaches the watchdog
    for (n = 0; n < 50 && ready !== 1'b1; n++)
      @(negedge clk);
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    // answer stands only between the two edges after the take
    @(negedge clk);
    got = rsp;
  endtask
endmodule

//--- bench/tb.sv
// Purpose: self-checking bench of the io space decoder
// Assumes: one request at a time through the core model
// Notes:   expected register contents kept in an int array

`timescale 1ns/100ps

module tb;
  import iod_pkg::*;
  logic        ref_clk;
  logic        rst;
  iod_req_t    req;
  logic        req_ready;
  iod_rsp_t    rsp;
  iod_pins_t   pins;
  iod_flags_t  flag_set;
  iod_low_t    low_regs;
  iod_ext_t    ext_bus;
  iod_ext_t    xe;
  iod_ext_t    ext_q [$];
  iod_rsp_t    got;
  logic [7:0]  ext_rdata;
  logic [31:0] seed;
  int          fail_count;
  int          cmp_count;
  int          e [64];
  logic [5:0]  tbl [14] = '{6'h05, 6'h07, 6'h0c, 6'h15, 6'h16, 6'h17, 6'h1b,
                            6'h1e, 6'h1f, 6'h23, 6'h24, 6'h2d, 6'h2a, 6'h3d};
  logic [7:0]  xa [3] = '{8'h60, 8'hff, 8'h9c};
  iod_op_t     bo [4] = '{SET_IO_BIT_OP, SKIP_IF_IO_BIT_HIGH_OP,
                          CLEAR_IO_BIT_OP, SKIP_IF_IO_BIT_LOW_OP};

  // ==========================================================
  // clock, dut and core model
  always #10 ref_clk = ~ref_clk;

  iod_decoder u_dut (.REF_CLK(ref_clk), .RST(rst), .REQ(req), .REQ_READY(req_ready),
    .RSP(rsp), .PINS(pins), .FLAG_SET(flag_set), .LOW_REGS(low_regs),
    .EXT_BUS(ext_bus), .EXT_RDATA(ext_rdata));

  iod_core_model u_core (.clk(ref_clk), .req(req), .ready(req_ready), .rsp(rsp));

  // ==========================================================
  // helpers
  function automatic int msk(logic [5:0] a);
    case (a)
      6'h03, 6'h04, 6'h05, 6'h09, 6'h0a, 6'h0b, 6'h1e: return 'hff;
      6'h20, 6'h21, 6'h22, 6'h26, 6'h27, 6'h28:        return 'hff;
      6'h2a, 6'h2b, 6'h2c, 6'h2e, 6'h30:               return 'hff;
      6'h06, 6'h07, 6'h08:               return 'h7f;
      6'h1d:                             return 'h03;
      6'h25:                             return 'hcf;
      6'h15, 6'h17, 6'h1b:               return 'h07;
      6'h16:                             return 'h27;
      6'h1f:                             return 'h3f;
      6'h23:                             return 'h83;
      6'h24:                             return 'hf3;
      6'h2d:                             return 'hc1;
      default:                           return 0;
    endcase
  endfunction

  function automatic logic [7:0] lowv(logic [5:0] a);
    case (a)
      6'h05:   return low_regs.out_b;
      6'h07:   return low_regs.ddr_c;
      6'h15:   return low_regs.tf0;
      6'h16:   return low_regs.tf1;
      6'h17:   return low_regs.tf2;
      6'h1b:   return low_regs.pcf;
      6'h1e:   return low_regs.scratch0;
      6'h1f:   return low_regs.ee_ctl;
      default: return 8'(e[a]);
    endcase
  endfunction

  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // pulse every flag set input for one cycle
  task automatic pulse();
    @(posedge ref_clk);
    flag_set <= '1;
    @(posedge ref_clk);
    flag_set <= '0;
    foreach (e[i])
      if (i inside {'h15, 'h16, 'h17, 'h1b})
        e[i] |= msk(6'(i));
  endtask

  // ==========================================================
  // one request plus its model; model runs after the answer so inputs are settled
  task automatic run(iod_op_t op, logic [7:0] a, logic [2:0] b = 3'h0, logic [7:0] w = 8'h00);
    iod_rsp_t   r;
    logic [5:0] io;
    int         m, d, xr, ign, sk, bm;
    bit         dat, ext, pin, bop, wc, rd;
    dat = op inside {DATA_LOAD_OP, DATA_SAVE_OP};
    ext = dat && a >= 8'h60;
    if (ext)
      ext_q.push_back(iod_ext_t'{1'b1, op == DATA_SAVE_OP, a,
                                 op == DATA_SAVE_OP ? w : 8'h00});
    u_core.xfer(iod_req_t'{1'b1, op, a, b, w}, r);
    io = dat ? 6'(a - 8'h20) : a[5:0];
    pin = io inside {6'h03, 6'h06, 6'h09};
    wc = io inside {6'h15, 6'h16, 6'h17, 6'h1b};
    bop = op inside {[SET_IO_BIT_OP:SKIP_IF_IO_BIT_LOW_OP]};
    rd = op inside {IO_READ_OP, DATA_LOAD_OP};
    m = msk(io);
    bm = 1 << b;
    ign = !ext && ((dat && a < 8'h20) || m == 0 || (bop && io > 6'h1f));
    d = ign ? 0 : pin ? ({pins.pin_b, pins.pin_c, pins.pin_d} >> (8 * (2 - io / 3 + 1))) & m
        : e[io];
    sk = ign ? 0 : op == SKIP_IF_IO_BIT_HIGH_OP ? d[b] : op == SKIP_IF_IO_BIT_LOW_OP ? !d[b] : 0;
    xr = !rd ? 0 : ext ? ext_rdata : d;
    chk("rsp_valid", r.valid, 1);
    chk("rsp_ignored", r.ignored, ign);
    chk("rsp_rdata", r.rdata, xr);
    chk("rsp_skip", r.skip, sk);
    if (!ign && op inside {SKIP_IF_IO_BIT_HIGH_OP, SKIP_IF_IO_BIT_LOW_OP})
      chk("rsp_bit", r.bit_val, d[b]);
    if (!ign && !pin && !ext)
      case (op)
        IO_WRITE_OP, DATA_SAVE_OP: e[io] = wc ? e[io] & ~(w & m) : w & m;
        SET_IO_BIT_OP:             e[io] = wc ? e[io] & ~(bm & m) : e[io] | (bm & m);
        CLEAR_IO_BIT_OP:           e[io] = wc ? e[io] : e[io] & ~bm;
        default:                   ;
      endcase
    chk("low_reg", lowv(io), e[io]);
    chk("ext_left", ext_q.size(), 0);
  endtask

  // ==========================================================
  // extended bus watcher, compares each request with the queue
  always @(posedge ref_clk)
    if (ext_bus.req === 1'b1)
    begin
      xe = ext_q.size() > 0 ? ext_q.pop_front() : '0;
      chk("ext_bus", {ext_bus.req, ext_bus.we, ext_bus.addr,
          ext_bus.we ? ext_bus.wdata : 8'h00}, xe);
    end

  // watchdog, well above the expected run of about 770 cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    end_of_test();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    ref_clk = 1'b0;
    rst = 1'b1;
    pins = '0;
    flag_set = '0;
    ext_rdata = 8'h00;
    seed = 32'h0001_62ba;
    fail_count = 0;
    cmp_count = 0;
    foreach (e[i])
      e[i] = 0;
    repeat (8) @(posedge ref_clk);
    chk("ready_rst", req_ready, 1);
    chk("rsp_rst", rsp, 0);
    chk("low_rst", |low_regs, 0);
    rst <= 1'b0;
    pins <= {rnd(), rnd(), rnd()};
    // plain and data space access of each register kind except the pin registers
    pulse();
    foreach (tbl[i])
    begin
      run(IO_READ_OP, tbl[i]);
      run(IO_WRITE_OP, tbl[i], 0, rnd());
      run(DATA_SAVE_OP, {2'h0, tbl[i]} + 8'h20, 0, rnd());
      run(DATA_LOAD_OP, {2'h0, tbl[i]} + 8'h20);
    end
    // one-to-clear flags: zero keeps, bit ops touch one flag only
    pulse();
    run(IO_WRITE_OP, 8'h15, 0, 8'h05);
    run(IO_WRITE_OP, 8'h15, 0, 8'h00);
    run(IO_WRITE_OP, 8'h16, 0, 8'h00);
    run(SET_IO_BIT_OP, 8'h16, 3'h5);
    run(CLEAR_IO_BIT_OP, 8'h16, 3'h0);
    run(SET_IO_BIT_OP, 8'h1b, 3'h1);
    // bit ops and skip tests, every bit, below and above the limit
    for (int b = 0; b < 8; b++)
    begin
      foreach (tbl[i])
        if (tbl[i] inside {6'h05, 6'h1e, 6'h1f, 6'h23, 6'h2a})
          foreach (bo[k])
            run(bo[k], {2'h3, tbl[i]}, 3'(b));
      run(SKIP_IF_IO_BIT_HIGH_OP, 8'h09, 3'(b));
      run(SKIP_IF_IO_BIT_LOW_OP, 8'h06, 3'(b));
    end
    // extended range by load/store only, core region refused
    foreach (xa[i])
    begin
      @(posedge ref_clk);
      ext_rdata <= rnd();
      run(DATA_LOAD_OP, xa[i]);
      run(DATA_SAVE_OP, xa[i], 0, rnd());
      run(IO_WRITE_OP, xa[i], 0, rnd());
    end
    run(DATA_SAVE_OP, 8'h10, 0, 8'h5a);
    run(DATA_LOAD_OP, 8'h10);
    run(IO_WRITE_OP, 8'h02, 0, 8'hff);
    // a flag raised in the clearing cycle survives the clear
    @(posedge ref_clk);
    flag_set.timer0 <= 8'h01;
    u_core.xfer(iod_req_t'{1'b1, IO_WRITE_OP, 8'h15, 3'h0, 8'h07}, got);
    chk("flag_set_wins", low_regs.tf0, 8'h01);
    flag_set <= '0;
    end_of_test();
  end
endmodule
